// File: core/udma_out_dev.sv
// Device end of an Ultra DMA data-out burst: handshake, dual-edge capture, CRC check
`timescale 1ns/10ps
module udma_out_dev (
    // Core clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Link: host strobe is the clock of the capture logic
    input  wire logic        hstrobe_clk,
    input  wire logic [15:0] dd_in,
    input  wire logic        stop_in,
    input  wire logic        dmack_n_in,
    output logic             dmarq,
    output logic             ddmardy_n_out,
    output logic             ddmardy_n_oe,
    // Command framing from the device controller
    input  wire logic        cmd_start,
    input  wire logic        cmd_end,
    input  wire logic        burst_req,
    input  wire logic        pause_req,
    input  wire logic        term_req,
    // Received words and status
    output logic [15:0]      word_data,
    output logic             word_valid,
    output logic             burst_busy,
    output logic             report_valid,
    output logic             report_crc_err
);

    // Burst phases, in the order a device-ended burst walks through them
    typedef enum logic [3:0] {
        S_IDLE,   // No burst; link lines keep their ordinary roles
        S_REQ,    // Request raised, waiting for the acknowledge
        S_ACK,    // Acknowledge seen, waiting before ready is driven
        S_INIT,   // Ready driven negated until STOP drops
        S_XFER,   // Ready asserted, words flow
        S_PAUSE,  // Ready negated, request held
        S_DRAIN,  // Ready negated to end the burst; late words still taken
        S_TERM,   // Request dropped, waiting for the acknowledge to negate
        S_CHECK   // Host CRC latched; compare once the last words have settled
    } state_t;

    localparam int CNT_W = udma_out_pkg::CNT_W;
    localparam logic [CNT_W-1:0] ZIORDY_CNT = CNT_W'(udma_out_pkg::CYC_ZIORDY);
    localparam logic [CNT_W-1:0] DRAIN_CNT  = CNT_W'(udma_out_pkg::CYC_RP + udma_out_pkg::CYC_SETTLE);
    localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(udma_out_pkg::CYC_SETTLE);

    if (udma_out_pkg::CYC_RP + udma_out_pkg::CYC_SETTLE >= (1 << CNT_W)) begin : g_chk_cnt
        $error("udma_out_dev: drain count does not fit the counter");
    end
    if (udma_out_pkg::WORD_W != 16) begin : g_chk_w
        $error("udma_out_dev: the link carries 16-bit words only");
    end
    if (udma_out_pkg::CYC_ZIORDY >= (1 << CNT_W)) begin : g_chk_zio
        $error("udma_out_dev: ready delay count does not fit the counter");
    end

    // ------------------------------------------------------------------
    // Strobe domain. The strobe may stand still outside bursts, so nothing
    // here waits for a later edge: each rising edge publishes a finished pair.
    // Limitation: rising edges must stand some five core cycles apart, or a
    // pair is overwritten before the core has taken it.
    // ------------------------------------------------------------------
    logic [15:0] fall_word;
    logic [15:0] pair_fall;
    logic [15:0] pair_rise;
    logic        pair_tog;

    always_ff @(negedge hstrobe_clk) begin
        fall_word <= dd_in;
    end

    // rising edge word and pair hand-off
    always_ff @(posedge hstrobe_clk) begin
        pair_rise <= dd_in;
        pair_fall <= fall_word;
        // Rises with the acknowledge negated are outside any burst and clear the toggle
        if (dmack_n_in) begin
            pair_tog <= 1'b0;
        end else begin
            pair_tog <= ~pair_tog;
        end
    end

    // ------------------------------------------------------------------
    // Core domain
    // ------------------------------------------------------------------
    logic [15:0] dd_s;
    logic        stop_s;
    // Acknowledge crosses inverted, so the flops' reset value equals its idle level
    // and no false negation edge follows reset
    logic        dmack_s;
    logic        tog_s;

    udma_sync2 #(
        .W (19)
    ) u_sync (
        .clk      (mclk),
        .rst_n    (rst_n),
        .async_in ({dd_in, stop_in, !dmack_n_in, pair_tog}),
        .sync_out ({dd_s, stop_s, dmack_s, tog_s})
    );

    wire logic dmack_n_s = !dmack_s;

    state_t           state;
    state_t           next_state;
    logic [CNT_W-1:0] cnt;
    logic             tog_seen;
    logic             rise_due;
    logic [15:0]      rise_hold;
    logic             pair_seen;
    logic             dmack_n_prev;
    logic [15:0]      dd_prev;
    logic [15:0]      host_crc;
    logic             err_seen;
    logic [15:0]      dev_crc;

    // burst meaning only while both handshake lines assert
    wire logic link_on      = dmarq && !dmack_n_s;
    wire logic new_pair     = (tog_s != tog_seen);
    wire logic tracking     = (state == S_IDLE) || (state == S_REQ);
    wire logic take_pair    = new_pair && !tracking;
    // Nothing still crossing from the strobe side; termination waits for this
    wire logic quiet        = !new_pair && !rise_due;
    wire logic ack_rise     = dmack_n_s && !dmack_n_prev;
    wire logic ack_lost     = dmack_n_s && (state inside {S_ACK, S_INIT, S_XFER, S_PAUSE, S_DRAIN});
    wire logic crc_bad      = (state == S_CHECK) && (cnt == SETTLE_CNT) && (host_crc != dev_crc);
    wire logic may_stop     = pair_seen && link_on;

    assign burst_busy = (state != S_IDLE);

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: begin
                if (burst_req && dmack_n_s) begin
                    next_state = S_REQ;
                end
            end
            S_REQ: begin
                if (!dmack_n_s) begin
                    next_state = S_ACK;
                end
            end
            S_ACK: begin
                if (ack_lost) begin
                    next_state = S_IDLE;
                end else if (cnt == ZIORDY_CNT) begin
                    next_state = S_INIT;
                end
            end
            S_INIT: begin
                // ready follows the release of STOP
                if (ack_lost) begin
                    next_state = S_IDLE;
                end else if (!stop_s) begin
                    next_state = S_XFER;
                end
            end
            S_XFER: begin
                // no pause or end before a word has moved
                if (ack_lost) begin
                    next_state = S_IDLE;
                end else if (term_req && may_stop) begin
                    next_state = S_DRAIN;
                end else if (pause_req && may_stop) begin
                    next_state = S_PAUSE;
                end
            end
            S_PAUSE: begin
                if (ack_lost) begin
                    next_state = S_IDLE;
                end else if (term_req) begin
                    next_state = S_DRAIN;
                end else if (!pause_req) begin
                    next_state = S_XFER;
                end
            end
            S_DRAIN: begin
                // hold request tRP past ready, plus crossing margin
                // Waiting for quiet keeps a late pair from landing after the request drops
                if (ack_lost) begin
                    next_state = S_IDLE;
                end else if (cnt >= DRAIN_CNT && quiet) begin
                    next_state = S_TERM;
                end
            end
            S_TERM: begin
                if (ack_rise) begin
                    next_state = S_CHECK;
                end
            end
            S_CHECK: begin
                if (cnt == SETTLE_CNT) begin
                    next_state = S_IDLE;
                end
            end
        endcase
    end

    // State and timing counter
    // Counter saturates so a long wait never wraps back onto a match
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                cnt <= '0;
            end else if (cnt != '1) begin
                cnt <= cnt + CNT_W'(1);
            end
        end
    end

    // Link outputs; ready stays driven from first drive until acknowledge negates
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dmarq         <= 1'b0;
            ddmardy_n_out <= 1'b1;
            ddmardy_n_oe  <= 1'b0;
        end else begin
            // request high from opening until the drain ends
            dmarq <= (next_state inside {S_REQ, S_ACK, S_INIT, S_XFER, S_PAUSE, S_DRAIN});
            // drive ready, negated, once tZIORDY has passed
            if (state == S_ACK && next_state == S_INIT) begin
                ddmardy_n_oe <= 1'b1;
            end
            // release as soon as acknowledge negation is seen
            if (ack_lost || ack_rise) begin
                ddmardy_n_oe <= 1'b0;
            end
            ddmardy_n_out <= (next_state != S_XFER);
        end
    end

    // Pair tracking and word delivery
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tog_seen   <= 1'b0;
            rise_due   <= 1'b0;
            rise_hold  <= '0;
            word_data  <= '0;
            word_valid <= 1'b0;
            pair_seen  <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (tracking) begin
                tog_seen  <= tog_s;
                rise_due  <= 1'b0;
                pair_seen <= 1'b0;
            end else if (take_pair) begin
                // every pair is taken, paused or not
                tog_seen   <= tog_s;
                word_data  <= pair_fall;
                word_valid <= 1'b1;
                rise_hold  <= pair_rise;
                pair_seen  <= 1'b1;
                // rise after the request drops carries no data
                rise_due   <= !(state inside {S_TERM, S_CHECK});
            end else if (rise_due) begin
                word_data  <= rise_hold;
                word_valid <= 1'b1;
                rise_due   <= 1'b0;
            end
        end
    end

    // CRC over delivered words, seeded at burst open
    // Words reach the CRC in link order, fall word before rise word
    udma_crc16 u_crc (
        .clk        (mclk),
        .rst_n      (rst_n),
        .seed_load  (state == S_IDLE && next_state == S_REQ),
        .word_valid (word_valid),
        .word       (word_data),
        .crc        (dev_crc)
    );

    // Host CRC capture and error record. The bus crosses through the same two flops
    // as the acknowledge, so the host must set its CRC up at least two core cycles
    // before negating the acknowledge; a faster host would need a latch clocked
    // by the acknowledge itself.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dmack_n_prev   <= 1'b1;
            dd_prev        <= '0;
            host_crc       <= '0;
            err_seen       <= 1'b0;
            report_valid   <= 1'b0;
            report_crc_err <= 1'b0;
        end else begin
            dmack_n_prev <= dmack_n_s;
            dd_prev      <= dd_s;
            // bus value sampled just before the acknowledge negation
            if (state == S_TERM && ack_rise) begin
                host_crc <= dd_prev;
            end
            // first error kept; a new error beats a same-cycle clear
            if (crc_bad) begin
                err_seen <= 1'b1;
            end else if (cmd_start) begin
                err_seen <= 1'b0;
            end
            // reported once, when the command ends
            report_valid <= cmd_end;
            if (cmd_end) begin
                report_crc_err <= err_seen || crc_bad;
            end
        end
    end

endmodule : udma_out_dev

// File: core/udma_out_pkg.sv
// Shared constants for the Ultra DMA data-out receiver
package udma_out_pkg;

    // Core clock rate
    localparam int MCLK_MHZ = 20;

    // Link timing figures in ns; plain defaults, set them to the selected mode
    localparam int T_ZIORDY_NS = 20;
    localparam int T_LI_NS     = 150;
    localparam int T_RP_NS     = 160;

    // Least times round up, longest times round down, never below one cycle
    localparam int CYC_ZIORDY_RAW = (T_ZIORDY_NS * MCLK_MHZ + 999) / 1000;
    localparam int CYC_ZIORDY     = (CYC_ZIORDY_RAW < 1) ? 1 : CYC_ZIORDY_RAW;
    localparam int CYC_RP_RAW     = (T_RP_NS * MCLK_MHZ + 999) / 1000;
    localparam int CYC_RP         = (CYC_RP_RAW < 1) ? 1 : CYC_RP_RAW;
    localparam int CYC_LI_RAW     = (T_LI_NS * MCLK_MHZ) / 1000;
    localparam int CYC_LI         = (CYC_LI_RAW < 1) ? 1 : CYC_LI_RAW;

    // Cycles allowed for strobe-domain events to cross after the link goes quiet
    localparam int CYC_SETTLE = 4;

    // Link word width and CRC definition
    localparam int          WORD_W   = 16;
    localparam logic [15:0] CRC_SEED = 16'h4aba;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // Counter width used for the timing counts above
    localparam int CNT_W = 4;

endpackage : udma_out_pkg

// File: core/udma_sync2.sv
// Two-flop synchroniser for a group of slow or qualified signals
`timescale 1ns/10ps
module udma_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous inputs and their synchronised copies
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    if (W < 1) begin : g_chk
        $error("udma_sync2: W must be at least 1");
    end

    // Stage one feeds only stage two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : udma_sync2

// File: core/udma_crc16.sv
// Running CRC-16 over the words of one burst
`timescale 1ns/10ps
module udma_crc16 (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control and data
    input  wire logic        seed_load,
    input  wire logic        word_valid,
    input  wire logic [15:0] word,
    // Result
    output logic      [15:0] crc
);

    // One 16-bit word folded in, most significant bit first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ udma_out_pkg::CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc_step

    wire logic [15:0] next_crc = crc_step(crc, word);

    always_ff @(posedge clk) begin
        if (!rst_n || seed_load) begin
            crc <= udma_out_pkg::CRC_SEED;
        end else if (word_valid) begin
            crc <= next_crc;
        end
    end

endmodule : udma_crc16

// File: dv/udma_out_dev_props.sv
// Port checks for the data-out receiver
`timescale 1ns/10ps
module udma_out_dev_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link pins
    input wire logic stop_in,
    input wire logic dmack_n_in,
    input wire logic dmarq,
    input wire logic ddmardy_n_out,
    input wire logic ddmardy_n_oe,
    // Control and status
    input wire logic burst_req,
    input wire logic pause_req,
    input wire logic term_req,
    input wire logic cmd_end,
    input wire logic burst_busy,
    input wire logic report_valid
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic [3:0] neg_cnt;
    // Cycles with ready negated, saturating so it never wraps
    always_ff @(posedge mclk) begin
        if (!rst_n || !ddmardy_n_out || !ddmardy_n_oe)
            neg_cnt <= 4'h0;
        else if (neg_cnt != 4'hf)
            neg_cnt <= neg_cnt + 4'h1;
    end
    property p_req_taken;
        burst_req && !burst_busy && dmack_n_in |=> dmarq;
    endproperty
    a_req_taken: assert property (p_req_taken) else $error("request not raised");
    property p_rdy_drive;
        $rose(ddmardy_n_oe) |-> ddmardy_n_out && !dmack_n_in && !$past(dmack_n_in);
    endproperty
    a_rdy_drive: assert property (p_rdy_drive) else $error("ready driven early");
    property p_rdy_hold;
        ddmardy_n_oe && !dmack_n_in |=> ddmardy_n_oe;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("ready released in burst");
    property p_rdy_release;
        $rose(dmack_n_in) && ddmardy_n_oe |-> ##[1:6] !ddmardy_n_oe;
    endproperty
    a_rdy_release: assert property (p_rdy_release) else $error("ready not released");
    property p_rdy_assert;
        $fell(stop_in) && !dmack_n_in && dmarq |-> ##[1:10] !ddmardy_n_out;
    endproperty
    a_rdy_assert: assert property (p_rdy_assert) else $error("ready late");
    property p_req_steady;
        dmarq && ddmardy_n_oe && !ddmardy_n_out |=> dmarq;
    endproperty
    a_req_steady: assert property (p_req_steady) else $error("request dropped while ready");
    property p_rp_gap;
        $fell(dmarq) |-> neg_cnt >= 4'(udma_out_pkg::CYC_RP);
    endproperty
    a_rp_gap: assert property (p_rp_gap) else $error("request dropped too soon");
    property p_pause_cause;
        $rose(ddmardy_n_out) && $past(ddmardy_n_oe) |-> dmarq && ($past(pause_req) || $past(term_req));
    endproperty
    a_pause_cause: assert property (p_pause_cause) else $error("ready negated uncalled");
    property p_report;
        cmd_end |=> report_valid;
    endproperty
    a_report: assert property (p_report) else $error("no report");
    c_burst: cover property ($rose(dmarq));
    c_pause: cover property ($rose(ddmardy_n_out) && dmarq);
    c_report: cover property (report_valid);
endmodule : udma_out_dev_props

bind udma_out_dev udma_out_dev_props u_props (
    .mclk(mclk), .rst_n(rst_n), .stop_in(stop_in), .dmack_n_in(dmack_n_in), .dmarq(dmarq),
    .ddmardy_n_out(ddmardy_n_out), .ddmardy_n_oe(ddmardy_n_oe), .burst_req(burst_req),
    .pause_req(pause_req), .term_req(term_req), .cmd_end(cmd_end), .burst_busy(burst_busy),
    .report_valid(report_valid)
);

// File: dv/udma_host_model.sv
// Behavioural host controller driving data-out bursts
`timescale 1ns/10ps
module udma_host_model (
    // Strobe, data and control to the device
    output logic        hstrobe_clk,
    output logic [15:0] dd_in,
    output logic        stop_in,
    output logic        dmack_n_in,
    // Device request and ready
    input  wire logic   dmarq,
    input  wire logic   ddmardy_n_out,
    input  wire logic   ddmardy_n_oe
);
    localparam int HALF  = 40;
    localparam int T_ACK = 40;
    localparam int T_ENV = 20;
    // Keeps the CRC standing over two core cycles before the acknowledge negates
    localparam int T_MLI = 120;
    localparam int T_DVS = 10;
    logic [15:0] tx_q[$];
    logic        bad_crc;
    logic [15:0] crc;
    int          sent;
    wire         ready = ddmardy_n_oe && !ddmardy_n_out;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--)
            r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? udma_out_pkg::CRC_POLY : 16'h0000);
        return r;
    endfunction : crc_step

    initial begin
        hstrobe_clk = 1'b0;
        dd_in = 16'h0000;
        stop_in = 1'b0;
        dmack_n_in = 1'b1;
        bad_crc = 1'b0;
        sent = 0;
    end

    always begin
        @(posedge dmarq);
        #13;
        // setup, fresh strobe rise, then acknowledge
        stop_in = 1'b1;
        hstrobe_clk = 1'b0;
        #HALF hstrobe_clk = 1'b1;
        crc = udma_out_pkg::CRC_SEED;
        sent = 0;
        #T_ACK dmack_n_in = 1'b0;
        #T_ENV stop_in = 1'b0;
        // word per edge while ready; long gap lets the core keep up
        while (dmarq) begin
            if (ready && tx_q.size() > 0) begin
                dd_in = tx_q.pop_front();
                crc = crc_step(crc, dd_in);
                sent++;
                #T_DVS hstrobe_clk = ~hstrobe_clk;
                #(hstrobe_clk ? 6 * HALF : HALF);
            end else begin
                #HALF;
            end
        end
        // STOP, strobe high without data, CRC on the bus
        stop_in = 1'b1;
        hstrobe_clk = 1'b1;
        dd_in = bad_crc ? ~crc : crc;
        #T_MLI dmack_n_in = 1'b1;
        #200 dd_in = ~dd_in;
        stop_in = 1'b0;
        tx_q.delete();
    end
endmodule : udma_host_model

// File: dv/udma_out_dev_bench.sv
// Self-checking bench for the data-out receiver
`timescale 1ns/10ps
module udma_out_dev_bench;
    logic        mclk;
    logic        rst_n;
    logic        cmd_start, cmd_end, burst_req, pause_req, term_req;
    wire         hstrobe_clk, stop_in, dmack_n_in, dmarq, ddmardy_n_out, ddmardy_n_oe;
    wire         word_valid, burst_busy, report_valid, report_crc_err;
    wire  [15:0] dd_in, word_data;
    logic [15:0] exp_q[$];
    logic [15:0] rx_q[$];
    int          failures;
    int          comparisons;

    udma_out_dev u_udma_out_dev (
        .mclk(mclk), .rst_n(rst_n), .hstrobe_clk(hstrobe_clk), .dd_in(dd_in), .stop_in(stop_in),
        .dmack_n_in(dmack_n_in), .dmarq(dmarq), .ddmardy_n_out(ddmardy_n_out), .ddmardy_n_oe(ddmardy_n_oe),
        .cmd_start(cmd_start), .cmd_end(cmd_end), .burst_req(burst_req), .pause_req(pause_req),
        .term_req(term_req), .word_data(word_data), .word_valid(word_valid), .burst_busy(burst_busy),
        .report_valid(report_valid), .report_crc_err(report_crc_err)
    );
    udma_host_model u_udma_host_model (
        .hstrobe_clk(hstrobe_clk), .dd_in(dd_in), .stop_in(stop_in), .dmack_n_in(dmack_n_in),
        .dmarq(dmarq), .ddmardy_n_out(ddmardy_n_out), .ddmardy_n_oe(ddmardy_n_oe)
    );

    initial mclk = 1'b0;
    always #25 mclk = ~mclk;
    // Sampled mid-cycle, where each one-cycle pulse has settled
    always @(negedge mclk)
        if (word_valid === 1'b1)
            rx_q.push_back(word_data);

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic cycles(input int n);
        repeat (n) @(negedge mclk);
    endtask : cycles

    task automatic new_cmd;
        cmd_start = 1'b1;
        cycles(1);
        cmd_start = 1'b0;
    endtask : new_cmd

    task automatic start_burst(input int n, input logic bad);
        exp_q.delete();
        rx_q.delete();
        for (int i = 0; i < n; i++)
            exp_q.push_back(16'ha5c3 ^ 16'(i * 16'h1111 + n));
        u_udma_host_model.tx_q = exp_q;
        u_udma_host_model.bad_crc = bad;
        burst_req = 1'b1;
        for (int i = 0; i < 10 && dmarq !== 1'b1; i++)
            cycles(1);
        burst_req = 1'b0;
        check("dmarq", 16'h1, 16'(dmarq));
    endtask : start_burst

    task automatic wait_words(input int k);
        for (int i = 0; i < 400 && rx_q.size() < k; i++)
            cycles(1);
    endtask : wait_words

    task automatic end_burst;
        term_req = 1'b1;
        for (int i = 0; i < 300 && burst_busy !== 1'b0; i++)
            cycles(1);
        term_req = 1'b0;
        check("burst_busy", 16'h0, 16'(burst_busy));
        check("word count", 16'(u_udma_host_model.sent), 16'(rx_q.size()));
        for (int i = 0; i < rx_q.size(); i++)
            check("word", exp_q[i], rx_q[i]);
        cycles(12);
    endtask : end_burst

    task automatic report(input logic err);
        cmd_end = 1'b1;
        cycles(1);
        cmd_end = 1'b0;
        check("report_valid", 16'h1, 16'(report_valid));
        check("report_crc_err", 16'(err), 16'(report_crc_err));
    endtask : report

    task automatic t_plain;
        new_cmd();
        start_burst(6, 1'b0);
        wait_words(6);
        end_burst();
        report(1'b0);
    endtask : t_plain

    task automatic t_pause;
        int c0;
        int k;
        new_cmd();
        start_burst(8, 1'b0);
        wait_words(2);
        pause_req = 1'b1;
        c0 = rx_q.size();
        cycles(6);
        check("ready negated", 16'h1, 16'(ddmardy_n_out));
        check("dmarq held", 16'h1, 16'(dmarq));
        cycles(30);
        k = rx_q.size();
        cycles(20);
        check("words while paused", 16'(k), 16'(rx_q.size()));
        check("extra words", 16'h1, 16'(k - c0 <= 3));
        pause_req = 1'b0;
        wait_words(8);
        end_burst();
        report(1'b0);
    endtask : t_pause

    task automatic t_early_term;
        new_cmd();
        term_req = 1'b1;
        start_burst(6, 1'b0);
        for (int i = 0; i < 400 && dmarq !== 1'b0; i++)
            cycles(1);
        check("pair before end", 16'h1, 16'(rx_q.size() >= 2));
        end_burst();
        report(1'b0);
    endtask : t_early_term

    task automatic t_crc;
        new_cmd();
        start_burst(4, 1'b1);
        wait_words(4);
        end_burst();
        start_burst(4, 1'b0);
        wait_words(4);
        end_burst();
        report(1'b1);
        new_cmd();
        start_burst(2, 1'b0);
        wait_words(2);
        end_burst();
        report(1'b0);
    endtask : t_crc

    initial begin
        rst_n = 1'b0;
        cmd_start = 1'b0;
        cmd_end = 1'b0;
        burst_req = 1'b0;
        pause_req = 1'b0;
        term_req = 1'b0;
        failures = 0;
        comparisons = 0;
        cycles(10);
        rst_n = 1'b1;
        cycles(2);
        check("reset dmarq", 16'h0, 16'(dmarq));
        check("reset ready drive", 16'h0, 16'(ddmardy_n_oe));
        t_plain();
        t_pause();
        t_early_term();
        t_crc();
        conclude();
    end

    // Whole run is a few tens of microseconds
    initial begin
        #300000;
        failures++;
        conclude();
    end
endmodule : udma_out_dev_bench
